/* File: reload_timer.sv */
// Added by the designer: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ns
`include "reload_timer_defines.svh"
// Summary of operation
// - one independent 16-bit down-counter per instance, nothing shared
// - cycle after load request, counter takes reload value; bit self-clears
// - enable and load together act in one cycle; load allowed anytime
// - clearing enable freezes count; setting it resumes from frozen value
// - low count read latches high byte; high read returns latched value
// - reload zero wraps through ffff for longest period; one is shortest
// - prescaler divides by 4,16,64 or 256; field 00 means divide by 4
// - single pass: stop at zero and hardware clears run enable
// - continuous: on step from one reload and keep counting until disabled
// - end-of-count flag only on step from one; loading zero sets none
// - enabled end of count raises interrupt; otherwise flag is polled
// - reading interrupt cause register clears it and drops request
// - clock select: system clock, rtc, rc oscillator or input pin
// - timer output starts low and toggles on each end of count
// - toggle logic always present; pin route only if allowed, no pwm
// - debug hold bit freezes counter while cpu halted at breakpoint
module reload_timer
  import reload_timer_pkg::*;
#(
  parameter bit HAS_PIN_ROUTE = 1'b1
) (
  input  wire logic                       ref_clk_i,
  input  wire logic                       srst_i,
  input  wire logic [3:0]                 avs_address_i,
  input  wire logic                       avs_read_i,
  input  wire logic                       avs_write_i,
  input  wire logic [31:0]                avs_writedata_i,
  input  wire logic [3:0]                 avs_byteenable_i,
  output logic      [31:0]                avs_readdata_o,
  output logic                            avs_waitrequest_o,
  input  wire reload_timer_pkg::clk_src_in_t src_i,
  input  wire logic                       debug_halt_i,
  output logic                            irq_o,
  output logic                            tout_o,
  output logic                            tout_pin_o
);
  import reload_timer_pkg::*;

  // refused at elaboration: the pin route is either built or it is not
  if (HAS_PIN_ROUTE != 1'b0 && HAS_PIN_ROUTE != 1'b1) begin : g_bad_route
    $error("HAS_PIN_ROUTE must be 0 or 1");
  end

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  clk_src_in_t src_s1_reg, src_s2_reg, src_s3_reg;
  logic        halt_s1_reg, halt_s2_reg;

  always_ff @(posedge ref_clk_i) begin
    src_s1_reg  <= src_i;
    src_s2_reg  <= src_s1_reg;
    src_s3_reg  <= src_s2_reg;
    halt_s1_reg <= debug_halt_i;
    halt_s2_reg <= halt_s1_reg;
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  timer_ctl_t  ctl_reg, ctl_next;
  logic        ier_reg, ier_next;
  logic        eoc_reg, eoc_next;
  logic [7:0]  rld_l_reg, rld_l_next;
  logic [7:0]  rld_h_reg, rld_h_next;
  logic [15:0] cnt_reg, cnt_next;          // private to this instance
  logic [7:0]  hold_h_reg, hold_h_next;
  logic [7:0]  pre_reg, pre_next;
  logic        pend_load_reg, pend_load_next;
  logic        tout_reg, tout_next;
  logic        route_reg, route_next;
  logic        pwm_reg, pwm_next;
  logic        irq_reg, irq_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        wait_reg, wait_next;

  // ---------------------------------------------------------------
  // source select and prescaler
  // ---------------------------------------------------------------
  logic       src_tick;
  logic [7:0] pre_last;
  logic       pre_tick;
  logic       frozen;
  logic       eoc_evt;
  logic       acc;
  logic       wr;
  logic       rd;

  always_comb begin
    case (ctl_reg.src)
      SRC_SYS: src_tick = 1'b1;
      SRC_RTC: src_tick = src_s2_reg.rtc & ~src_s3_reg.rtc;
      SRC_RC:  src_tick = src_s2_reg.rc  & ~src_s3_reg.rc;
      SRC_PIN: src_tick = src_s2_reg.pin & ~src_s3_reg.pin;
      default: src_tick = 1'b0;
    endcase
    case (ctl_reg.div)
      DIV_4:   pre_last = `DIV4_LAST;
      DIV_16:  pre_last = `DIV16_LAST;
      DIV_64:  pre_last = `DIV64_LAST;
      DIV_256: pre_last = `DIV256_LAST;
      default: pre_last = `DIV4_LAST;
    endcase
  end

  // debug hold wins over the enable but never over a pending load
  assign frozen   = ctl_reg.debug_hold_bit & halt_s2_reg;
  assign pre_tick = ctl_reg.run_enable_bit & ~frozen & src_tick
                    & (pre_reg == pre_last);
  // flag only on a real step from one; a loaded zero never counts
  assign eoc_evt  = pre_tick & ~pend_load_reg
                    & (cnt_reg == `COUNT_ONE);

  // ---------------------------------------------------------------
  // bus access: one wait cycle, answer on the second edge
  // ---------------------------------------------------------------
  // first edge: read data and read side effects are registered and
  // waitrequest drops; second edge: the master takes the answer and a
  // write lands. a write is used only once waitrequest is low, so the
  // master's data is known to stand when it is taken.
  assign acc = (avs_read_i | avs_write_i) & wait_reg;
  assign wr  = avs_write_i & ~wait_reg & avs_byteenable_i[0];
  assign rd  = avs_read_i & wait_reg;

  always_comb begin
    ctl_next       = ctl_reg;
    ier_next       = ier_reg;
    eoc_next       = eoc_reg;
    rld_l_next     = rld_l_reg;
    rld_h_next     = rld_h_reg;
    cnt_next       = cnt_reg;
    hold_h_next    = hold_h_reg;
    pre_next       = pre_reg;
    pend_load_next = pend_load_reg;
    tout_next      = tout_reg;
    route_next     = route_reg;
    pwm_next       = pwm_reg;
    rdata_next     = '0;
    wait_next      = 1'b1;

    // prescaler and counter
    if (ctl_reg.run_enable_bit && !frozen && src_tick) begin
      pre_next = (pre_reg == pre_last) ? `PRE_ZERO : pre_reg + 8'h01;
    end
    if (pend_load_reg) begin
      cnt_next       = {rld_h_reg, rld_l_reg};
      pend_load_next = 1'b0;
      pre_next       = `PRE_ZERO;
    end else if (pre_tick) begin
      if (cnt_reg == `COUNT_ONE) begin
        tout_next = ~tout_reg;
        if (ctl_reg.repeat_mode_bit) begin
          cnt_next = {rld_h_reg, rld_l_reg};
        end else begin
          cnt_next = `COUNT_ZERO;
          ctl_next.run_enable_bit = 1'b0;
        end
      end else begin
        // zero wraps to ffff, giving the longest period
        cnt_next = cnt_reg - `COUNT_ONE;
      end
    end

    // register writes
    if (wr) begin
      case (avs_address_i)
        `OFF_CTL: begin
          ctl_next = timer_ctl_t'(avs_writedata_i[7:0]);
          ctl_next.load_request_bit = 1'b0;
          if (avs_writedata_i[`CTL_LOAD]) begin
            pend_load_next = 1'b1;
          end
        end
        `OFF_IER:     ier_next   = avs_writedata_i[`IER_EOC];
        `OFF_RLD_L:   rld_l_next = avs_writedata_i[7:0];
        `OFF_RLD_H:   rld_h_next = avs_writedata_i[7:0];
        `OFF_PIN_CTL: begin
          route_next = avs_writedata_i[`PIN_ROUTE];
          pwm_next   = avs_writedata_i[`PIN_PWM];
        end
        default: ;
      endcase
    end

    // register reads
    if (rd) begin
      case (avs_address_i)
        `OFF_CTL: rdata_next[7:0] = ctl_reg;
        `OFF_IIR: begin
          rdata_next[`IIR_EOC] = eoc_reg;
          eoc_next = 1'b0;
        end
        `OFF_IER:   rdata_next[`IER_EOC] = ier_reg;
        `OFF_CNT_L: begin
          rdata_next[7:0] = cnt_reg[7:0];
          hold_h_next     = cnt_reg[15:8];
        end
        `OFF_CNT_H:   rdata_next[7:0] = hold_h_reg;
        `OFF_RLD_L:   rdata_next[7:0] = rld_l_reg;
        `OFF_RLD_H:   rdata_next[7:0] = rld_h_reg;
        `OFF_PIN_CTL: rdata_next[1:0] = {pwm_reg, route_reg};
        default:      rdata_next = '0;
      endcase
    end

    // the event wins over a clearing read in the same cycle
    if (eoc_evt) begin
      eoc_next = 1'b1;
    end
    // waitrequest is low for exactly one cycle per access
    if (acc) begin
      wait_next = 1'b0;
    end
  end

  assign irq_next = eoc_next & ier_next;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ctl_reg       <= timer_ctl_t'(`CTL_RST);
      ier_reg       <= 1'b0;
      eoc_reg       <= 1'b0;
      rld_l_reg     <= 8'h00;
      rld_h_reg     <= 8'h00;
      cnt_reg       <= `COUNT_ZERO;
      hold_h_reg    <= 8'h00;
      pre_reg       <= `PRE_ZERO;
      pend_load_reg <= 1'b0;
      tout_reg      <= 1'b0;
      route_reg     <= 1'b0;
      pwm_reg       <= 1'b0;
      irq_reg       <= 1'b0;
      rdata_reg     <= 32'h0000_0000;
      wait_reg      <= 1'b1;
    end else begin
      ctl_reg       <= ctl_next;
      ier_reg       <= ier_next;
      eoc_reg       <= eoc_next;
      rld_l_reg     <= rld_l_next;
      rld_h_reg     <= rld_h_next;
      cnt_reg       <= cnt_next;
      hold_h_reg    <= hold_h_next;
      pre_reg       <= pre_next;
      pend_load_reg <= pend_load_next;
      tout_reg      <= tout_next;
      route_reg     <= route_next;
      pwm_reg       <= pwm_next;
      irq_reg       <= irq_next;
      rdata_reg     <= rdata_next;
      wait_reg      <= wait_next;
    end
  end

  // pin copy registered so the output comes from a flip-flop
  logic tout_pin_reg;
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      tout_pin_reg <= 1'b0;
    end else begin
      // next values, so the pin never lags the routing bits by a cycle
      tout_pin_reg <= HAS_PIN_ROUTE & route_next & ~pwm_next
                      & tout_next;
    end
  end

  assign avs_readdata_o    = rdata_reg;
  assign avs_waitrequest_o = wait_reg;
  assign irq_o             = irq_reg;
  assign tout_o            = tout_reg;
  assign tout_pin_o        = tout_pin_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  load_takes_a: assert property (pend_load_reg |=>
      cnt_reg == $past({rld_h_reg, rld_l_reg}))
    else $error("load did not take reload value");
  load_clear_a: assert property (!ctl_reg.load_request_bit)
    else $error("load request bit not cleared");
  freeze_a: assert property (!ctl_reg.run_enable_bit && !pend_load_reg
      && !(wr && avs_address_i == `OFF_CTL) |=> $stable(cnt_reg))
    else $error("counter moved while disabled");
  hold_read_a: assert property (rd && avs_address_i == `OFF_CNT_L
      |=> hold_h_reg == $past(cnt_reg[15:8]))
    else $error("high byte not latched");
  wrap_a: assert property (pre_tick && !pend_load_reg
      && cnt_reg == `COUNT_ZERO |=> cnt_reg == 16'hffff)
    else $error("zero did not wrap");
  single_stop_a: assert property (eoc_evt && !ctl_reg.repeat_mode_bit
      && !wr |=> !ctl_reg.run_enable_bit && cnt_reg == `COUNT_ZERO)
    else $error("single pass did not stop");
  repeat_a: assert property (eoc_evt && ctl_reg.repeat_mode_bit
      |=> cnt_reg == $past({rld_h_reg, rld_l_reg}))
    else $error("continuous did not reload");
  flag_a: assert property (eoc_evt |=> eoc_reg)
    else $error("end of count flag missing");
  irq_a: assert property (irq_o |-> eoc_reg && ier_reg)
    else $error("irq without cause");
  iir_clear_a: assert property (rd && avs_address_i == `OFF_IIR
      && !eoc_evt |=> !eoc_reg && !irq_o)
    else $error("cause read did not clear");
  toggle_a: assert property (eoc_evt |=> tout_o != $past(tout_o))
    else $error("output did not toggle");
  hold_a: assert property (frozen && !pend_load_reg
      && !(wr && avs_address_i == `OFF_CTL) |=> $stable(cnt_reg))
    else $error("counter moved in debug hold");
  load_start_a: assert property (wr && avs_address_i == `OFF_CTL
      && avs_writedata_i[`CTL_LOAD] |=> pend_load_reg
      && ctl_reg.run_enable_bit == $past(avs_writedata_i[`CTL_EN]))
    else $error("enable and load not taken together");
  run_stays_a: assert property (!ctl_reg.run_enable_bit
      && !(wr && avs_address_i == `OFF_CTL) |=> !ctl_reg.run_enable_bit)
    else $error("timer restarted without software");
  eoc_src_a: assert property ($rose(eoc_reg)
      |-> $past(eoc_evt))
    else $error("flag set without a step from one");
  tout_still_a: assert property (!eoc_evt
      |=> $stable(tout_o))
    else $error("output moved without end of count");
  pin_pwm_a: assert property (pwm_reg |-> !tout_pin_o)
    else $error("pin driven while pwm owns it");
  pin_copy_a: assert property (tout_pin_o |-> tout_o)
    else $error("pin differs from timer output");
  step_a: assert property (pre_tick && !pend_load_reg
      && cnt_reg != `COUNT_ONE |=> cnt_reg == $past(cnt_reg) - `COUNT_ONE)
    else $error("counter did not step by one");

  // ---------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------
  // a master that held its request past the answer would be served
  // twice; these catch the slave side of that contract only
  ack_next_a: assert property ((avs_read_i || avs_write_i)
      && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("no answer one cycle after request");
  ack_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  rdata_idle_a: assert property (avs_waitrequest_o
      |-> avs_readdata_o == 32'h0000_0000)
    else $error("read data outside an answer");

  // ---------------------------------------------------------------
  // cover
  // ---------------------------------------------------------------
  cov_eoc_c:    cover property (eoc_evt);
  cov_reload_c: cover property (pend_load_reg && ctl_reg.run_enable_bit);
  cov_repeat_c: cover property (eoc_evt && ctl_reg.repeat_mode_bit);
  cov_irq_c:    cover property ($rose(irq_o));
  cov_hold_c:   cover property (frozen && ctl_reg.run_enable_bit);
endmodule

/* File: reload_timer_defines.svh */
`ifndef RELOAD_TIMER_DEFINES_SVH
`define RELOAD_TIMER_DEFINES_SVH

// ---------------------------------------------------------------
// register offsets (word addresses, one word each)
// ---------------------------------------------------------------
`define OFF_CTL       4'h0
`define OFF_IIR       4'h1
`define OFF_IER       4'h2
`define OFF_CNT_L     4'h3
`define OFF_CNT_H     4'h4
`define OFF_RLD_L     4'h5
`define OFF_RLD_H     4'h6
`define OFF_PIN_CTL   4'h7

// ---------------------------------------------------------------
// register fields: control, interrupt cause, interrupt enable and pin control
// ---------------------------------------------------------------
`define CTL_EN        0
`define CTL_LOAD      1
`define CTL_DIV_LO    2
`define CTL_DIV_HI    3
`define CTL_SEL_LO    4
`define CTL_SEL_HI    5
`define CTL_REPEAT    6
`define CTL_HOLD      7
`define IIR_EOC       0
`define IER_EOC       0
`define PIN_ROUTE     0
`define PIN_PWM       1

// ---------------------------------------------------------------
// reset values and constants
// ---------------------------------------------------------------
`define CTL_RST       8'h00
`define IER_RST       8'h00
`define COUNT_ZERO    16'h0000
`define COUNT_ONE     16'h0001
`define PRE_ZERO      8'h00
`define DIV4_LAST     8'h03
`define DIV16_LAST    8'h0f
`define DIV64_LAST    8'h3f
`define DIV256_LAST   8'hff

`endif

/* File: reload_timer_pkg.sv */
package reload_timer_pkg;

  typedef enum logic [1:0] {
    SRC_SYS = 2'b00,
    SRC_RTC = 2'b01,
    SRC_RC  = 2'b10,
    SRC_PIN = 2'b11
  } clk_src_t;

  typedef enum logic [1:0] {
    DIV_4   = 2'b00,
    DIV_16  = 2'b01,
    DIV_64  = 2'b10,
    DIV_256 = 2'b11
  } clk_div_t;

  typedef struct packed {
    logic     debug_hold_bit;
    logic     repeat_mode_bit;
    clk_src_t src;
    clk_div_t div;
    logic     load_request_bit;
    logic     run_enable_bit;
  } timer_ctl_t;

  typedef struct packed {
    logic rtc;
    logic rc;
    logic pin;
  } clk_src_in_t;

endpackage

/* File: src_model.sv */
`timescale 1ns/1ns
module src_model
  import reload_timer_pkg::*;
(
  input  wire logic                       clk_i,
  input  wire logic [2:0]                 run_i,
  output reload_timer_pkg::clk_src_in_t   src_o
);
  // ------------------------------------------------------------
  // slow source lines, each toggles every 8 cycles while run
  // ------------------------------------------------------------
  logic [2:0] cnt_reg = 3'h0;
  initial src_o = '0;
  // a stopped line stands still, so a wrong source select shows
  always @(posedge clk_i) begin
    cnt_reg <= cnt_reg + 3'h1;
    if (cnt_reg == 3'h7) begin
      src_o <= src_o ^ run_i;
    end
  end
endmodule

/* File: programmable_reload_timer_tb.sv */
`timescale 1ns/1ns
`include "reload_timer_defines.svh"
module programmable_reload_timer_tb;
  import reload_timer_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        wreq;
  logic [2:0]  run = 3'h0;
  logic        halt = 1'b0;
  logic        irq;
  logic        tout;
  logic        tpin;
  clk_src_in_t src;
  int          bad_count = 0;
  int          check_count = 0;
  logic [7:0]  v, lo, hi;
  logic [15:0] f;
  int          n;

  always #4 clk = ~clk;

  reload_timer #(.HAS_PIN_ROUTE(1'b1)) dut (
    .ref_clk_i(clk), .srst_i(srst), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(4'hf), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .src_i(src), .debug_halt_i(halt),
    .irq_o(irq), .tout_o(tout), .tout_pin_o(tpin));

  src_model partner (.clk_i(clk), .run_i(run), .src_o(src));

  // ------------------------------------------------------------
  // bus and check tasks
  // ------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("Error t=%0t got %h exp %h", $time, got, exp);
      bad_count++;
    end
  endtask

  // request held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [3:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    int k;
    addr <= a;
    wdata <= {24'h0, d};
    wr <= w;
    rd <= ~w;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wreq !== 1'b0 && k < 20);
    if (k >= 20) begin
      bad_count++;
      end_sim();
    end
    q = rdata[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic w8(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, a, d, q);
  endtask

  task automatic r8(input logic [3:0] a, output logic [7:0] q);
    acc(1'b0, a, 8'h00, q);
  endtask

  // waits for irq or a tout change, bounded
  task automatic wait_ev(input int lim, output int k);
    logic t0;
    t0 = tout;
    k = 0;
    while (irq !== 1'b1 && tout === t0 && k < lim) begin
      @(posedge clk);
      k++;
    end
    if (k >= lim) begin
      bad_count++;
      end_sim();
    end
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    end_sim();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    r8(`OFF_CTL, v); chk(v, 8'h00);
    chk(tout, 1'b0);
    w8(`OFF_IER, 8'h01);
    w8(`OFF_RLD_H, 8'h00);
    w8(`OFF_RLD_L, 8'h01);
    for (int d = 0; d < 4; d++) begin
      w8(`OFF_CTL, {4'h0, d[1:0], 2'b11});
      wait_ev(400, n);
      chk(n >= (4 << (2 * d)) - 2 && n <= (4 << (2 * d)) + 6, 1);
      chk(irq, 1'b1);
      r8(`OFF_CTL, v); chk(v[1:0], 2'b00);
      r8(`OFF_IIR, v); chk(v, 8'h01);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      chk(tout, {31'h0, ~d[0]});
    end
    r8(`OFF_CNT_L, v); chk(v, 8'h00);
    // freeze and resume without reload
    w8(`OFF_RLD_H, 8'h01);
    w8(`OFF_RLD_L, 8'h00);
    w8(`OFF_CTL, 8'h03);
    repeat (40) @(posedge clk);
    w8(`OFF_CTL, 8'h00);
    r8(`OFF_CNT_L, lo);
    r8(`OFF_CNT_H, hi);
    f = {hi, lo};
    chk(f > 16'h00e0 && f < 16'h0100, 1);
    repeat (40) @(posedge clk);
    r8(`OFF_CNT_L, v); chk(v, lo);
    w8(`OFF_CTL, 8'h01);
    repeat (40) @(posedge clk);
    r8(`OFF_CNT_L, lo);
    r8(`OFF_CNT_H, hi);
    chk({hi, lo} < f && {hi, lo} > f - 16'h0020, 1);
    // high byte read alone returns the stale latch
    w8(`OFF_RLD_H, 8'h34);
    w8(`OFF_CTL, 8'h02);
    r8(`OFF_CNT_H, v); chk(v, 8'h00);
    r8(`OFF_CNT_L, v); chk(v, 8'h00);
    r8(`OFF_CNT_H, v); chk(v, 8'h34);
    // reload of zero: no flag, wraps to all ones
    w8(`OFF_RLD_H, 8'h00);
    w8(`OFF_RLD_L, 8'h00);
    w8(`OFF_CTL, 8'h02);
    r8(`OFF_IIR, v); chk(v, 8'h00);
    w8(`OFF_CTL, 8'h01);
    repeat (10) @(posedge clk);
    r8(`OFF_CNT_L, v);
    r8(`OFF_CNT_H, v); chk(v, 8'hff);
    // continuous mode, interrupt masked, pin routing
    w8(`OFF_IER, 8'h00);
    w8(`OFF_RLD_L, 8'h03);
    w8(`OFF_CTL, 8'h43);
    w8(`OFF_PIN_CTL, 8'h01);
    for (int i = 0; i < 3; i++) begin
      wait_ev(60, n);
      chk(irq, 1'b0);
      repeat (3) @(posedge clk);
      chk(tpin, tout);
    end
    r8(`OFF_CTL, v); chk(v[0], 1'b1);
    r8(`OFF_IIR, v); chk(v, 8'h01);
    w8(`OFF_PIN_CTL, 8'h03);
    wait_ev(60, n);
    repeat (3) @(posedge clk);
    chk(tpin, 1'b0);
    // debug hold
    w8(`OFF_RLD_L, 8'h80);
    w8(`OFF_CTL, 8'hc3);
    halt <= 1'b1;
    repeat (5) @(posedge clk);
    r8(`OFF_CNT_L, lo);
    repeat (30) @(posedge clk);
    r8(`OFF_CNT_L, v); chk(v, lo);
    w8(`OFF_CTL, 8'h41);
    repeat (8) @(posedge clk);
    r8(`OFF_CNT_L, v); chk(v < lo, 1);
    halt <= 1'b0;
    // other clock sources count only while their line moves
    for (int s = 1; s < 4; s++) begin
      w8(`OFF_CTL, {2'b00, s[1:0], 4'h3});
      repeat (100) @(posedge clk);
      r8(`OFF_CNT_L, v); chk(v, 8'h80);
      run <= 3'h1 << (3 - s);
      repeat (150) @(posedge clk);
      r8(`OFF_CNT_L, v); chk(v < 8'h80, 1);
      run <= 3'h0;
    end
    r8(4'h9, v); chk(v, 8'h00);
    end_sim();
  end
endmodule
